// File: core/asac_fifo.sv
// small valid/ready fifo for delay return samples
`timescale 1ns/1ps
module asac_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// ============================================================
	// handshake
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = clk_en && in_valid && in_ready;
	assign pop = clk_en && out_valid && out_ready;
	assign out_data = mem_q[rd_q]; // array is flop storage

	// storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : asac_fifo

// File: core/asac_pkg.sv
// constants for the aux serial audio clocking block
package asac_pkg;
	// master clock frequency select codes
	localparam logic [1:0] FREQ_18M432 = 2'h0;
	localparam logic [1:0] FREQ_24M576 = 2'h1;
	localparam logic [1:0] FREQ_27M000 = 2'h2;
	// adc source: master clocks per frame and bit clocks per frame
	localparam int unsigned ADC_DIV_384 = 384;
	localparam int unsigned ADC_DIV_512 = 512;
	localparam int unsigned BITS_48 = 48;
	localparam int unsigned BITS_64 = 64;
	// master clock output start delay in master clock periods
	localparam int unsigned MCLK_START_PERIODS = 1024;
	// clock source selection time
	localparam int unsigned CLK_CLOCK_MHZ = 100;
	localparam int unsigned SRC_SEL_TIME_MS = 10;
	localparam int unsigned SRC_SEL_CYCLES = SRC_SEL_TIME_MS * CLK_CLOCK_MHZ * 1000;
	// master clocks seen on the applied pin within the probe window to call it present
	localparam int unsigned PIN_PRESENT_EDGES = 16;
	// state of the source selector
	typedef enum logic [2:0] {
		ASAC_SEL_WAIT = 3'b001,
		ASAC_SEL_PIN = 3'b010,
		ASAC_SEL_XTAL = 3'b100
	} asac_sel_t;
endpackage : asac_pkg

// File: core/asac_top.sv
// aux serial audio port clock, frame and master clock output generation
// ============================================================
// What this block does
// - select code 00/01/10 names master clock 18.432/24.576/27.000 MHz
// - adc source: aux frame and bit clocks have 50 percent duty
// - passthrough at 32/44.1/48 kHz: aux frame and bit clocks follow input
// - passthrough edges regenerated on ref_clk, jitter up to one ref_clk period
// - master clock output starts only after 1024 master clocks once the source is chosen
// - crystal source only allowed in software mode; strap mode needs pin clock
// - code 10 accepted only in software mode; strap mode offers 00 and 01
// - choose pin clock or crystal within 10 ms of reset release
`timescale 1ns/1ps
module asac_top #(
	parameter int unsigned SRC_SEL_CYCLES = asac_pkg::SRC_SEL_CYCLES,
	parameter int unsigned FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic software_mode,
	input wire logic [1:0] master_clock_freq_select,
	input wire logic global_powerdown,
	input wire logic source_is_serial,
	input wire logic rate_is_96k,
	input wire logic master_clock_pin,
	input wire logic crystal_input,
	input wire logic input_frame_clock,
	input wire logic input_bit_clock,
	input wire logic delay_return_data_in,
	output logic master_clock_out,
	output logic master_clock_out_en,
	output logic use_crystal,
	output logic aux_frame_clock,
	output logic aux_bit_clock,
	output logic ret_valid,
	input wire logic ret_ready,
	output logic ret_data,
	output logic ret_overflow
);
	// ============================================================
	// input synchronisers, two flops each; bit 1 pin clock up to bit 5 return data
	logic [5:1] s1_q;
	logic [5:1] s2_q;
	logic [5:1] s3_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (clk_en) begin
			s1_q <= {delay_return_data_in, input_bit_clock, input_frame_clock,
				crystal_input, master_clock_pin};
			s2_q <= s1_q;
			s3_q <= s2_q; // history for edge detection
		end
	end
	logic pin_rise;
	logic xtal_rise;
	logic lr_edge;
	logic bc_rise;
	logic bc_edge;
	assign pin_rise = s2_q[1] && !s3_q[1];
	assign xtal_rise = s2_q[2] && !s3_q[2];
	assign lr_edge = s2_q[3] != s3_q[3];
	assign bc_rise = s2_q[4] && !s3_q[4];
	assign bc_edge = s2_q[4] != s3_q[4];

	// ============================================================
	// effective select code; strap mode cannot ask for 27 MHz
	logic [1:0] freq_sel;
	assign freq_sel = (!software_mode && master_clock_freq_select == asac_pkg::FREQ_27M000) ?
		asac_pkg::FREQ_24M576 : master_clock_freq_select;

	// ============================================================
	// source selection within the probe window after reset
	asac_pkg::asac_sel_t sel_q;
	logic [31:0] sel_cnt_q;
	logic [4:0] pin_edges_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_q <= asac_pkg::ASAC_SEL_WAIT;
			sel_cnt_q <= '0;
			pin_edges_q <= '0;
		end else if (clk_en) begin
			unique case (sel_q)
				asac_pkg::ASAC_SEL_WAIT: begin
					sel_cnt_q <= sel_cnt_q + 32'h0000_0001;
					if (pin_rise && pin_edges_q != 5'(asac_pkg::PIN_PRESENT_EDGES)) begin
						pin_edges_q <= pin_edges_q + 5'h01;
					end
					// strap mode always uses the pin: no crystal driver there
					if (pin_edges_q == 5'(asac_pkg::PIN_PRESENT_EDGES) || !software_mode) begin
						sel_q <= asac_pkg::ASAC_SEL_PIN;
					end else if (sel_cnt_q >= SRC_SEL_CYCLES - 1) begin
						sel_q <= asac_pkg::ASAC_SEL_XTAL;
					end
				end
				asac_pkg::ASAC_SEL_PIN: sel_q <= asac_pkg::ASAC_SEL_PIN;
				asac_pkg::ASAC_SEL_XTAL: sel_q <= asac_pkg::ASAC_SEL_XTAL;
				default: sel_q <= asac_pkg::ASAC_SEL_WAIT;
			endcase
		end
	end
	assign use_crystal = (sel_q == asac_pkg::ASAC_SEL_XTAL);
	logic mclk_tick;
	logic mclk_level;
	assign mclk_tick = use_crystal ? xtal_rise : pin_rise;
	assign mclk_level = use_crystal ? s2_q[2] : s2_q[1];

	// ============================================================
	// master clock output held off for 1024 master clocks after the source is chosen
	logic [10:0] start_cnt_q;
	logic mclk_on_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_cnt_q <= '0;
			mclk_on_q <= 1'b0;
			master_clock_out <= 1'b0;
		end else if (clk_en) begin
			if (!mclk_on_q && sel_q != asac_pkg::ASAC_SEL_WAIT && mclk_tick) begin
				start_cnt_q <= start_cnt_q + 11'h001;
				if (start_cnt_q == 11'(asac_pkg::MCLK_START_PERIODS - 1)) begin
					mclk_on_q <= 1'b1;
				end
			end
			master_clock_out <= mclk_on_q && mclk_level;
		end
	end
	assign master_clock_out_en = mclk_on_q;

	// ============================================================
	// adc source: divide master clock into bit and frame clocks
	// half bit period is 4 master clocks either way (384/48/2, 512/64/2)
	localparam int unsigned HALF_BIT = asac_pkg::ADC_DIV_384 / asac_pkg::BITS_48 / 2;
	logic [1:0] hb_cnt_q;
	logic [5:0] bit_cnt_q;
	logic adc_bc_q;
	logic adc_lr_q;
	logic [5:0] half_frame;
	assign half_frame = (freq_sel == asac_pkg::FREQ_18M432) ?
		6'(asac_pkg::BITS_48 / 2 - 1) : 6'(asac_pkg::BITS_64 / 2 - 1);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hb_cnt_q <= '0;
			bit_cnt_q <= '0;
			adc_bc_q <= 1'b0;
			adc_lr_q <= 1'b0;
		end else if (clk_en && mclk_tick && !global_powerdown) begin
			hb_cnt_q <= hb_cnt_q + 2'h1;
			if (hb_cnt_q == 2'(HALF_BIT - 1)) begin
				adc_bc_q <= !adc_bc_q;
				// frame clock flips on bit clock falling edge, equal halves
				if (adc_bc_q) begin
					if (bit_cnt_q >= half_frame) begin
						bit_cnt_q <= '0;
						adc_lr_q <= !adc_lr_q;
					end else begin
						bit_cnt_q <= bit_cnt_q + 6'h01;
					end
				end
			end
		end
	end

	// ============================================================
	// passthrough: edges regenerated on ref_clk, so up to one clock of jitter
	logic pt_bc_q;
	logic pt_lr_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pt_bc_q <= 1'b0;
			pt_lr_q <= 1'b0;
		end else if (clk_en) begin
			if (rate_is_96k) begin
				if (bc_rise) begin
					pt_bc_q <= !pt_bc_q;
				end
				if (lr_edge && s2_q[3]) begin
					pt_lr_q <= !pt_lr_q;
				end
			end else begin
				if (bc_edge) begin
					pt_bc_q <= s2_q[4];
				end
				if (lr_edge) begin
					pt_lr_q <= s2_q[3];
				end
			end
		end
	end

	// output clocks registered
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_frame_clock <= 1'b0;
			aux_bit_clock <= 1'b0;
		end else if (clk_en) begin
			aux_frame_clock <= source_is_serial ? pt_lr_q : adc_lr_q;
			aux_bit_clock <= source_is_serial ? pt_bc_q : adc_bc_q;
		end
	end

	// ============================================================
	// delay return bits captured on aux bit clock rise, buffered
	logic aux_bc_prev_q;
	logic cap_valid;
	logic cap_ready;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_bc_prev_q <= 1'b0;
			ret_overflow <= 1'b0;
		end else if (clk_en) begin
			aux_bc_prev_q <= aux_bit_clock;
			if (cap_valid && !cap_ready) begin
				ret_overflow <= 1'b1; // sample lost, sticky until reset
			end
		end
	end
	assign cap_valid = aux_bit_clock && !aux_bc_prev_q;

	asac_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) asac_fifo_inst (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(cap_valid),
		.in_ready(cap_ready),
		.in_data(s2_q[5]),
		.out_valid(ret_valid),
		.out_ready(ret_ready),
		.out_data(ret_data)
	);

	// ============================================================
	// checks
	property p_start_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!mclk_on_q |-> start_cnt_q <= 11'(asac_pkg::MCLK_START_PERIODS);
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start counter overran");
	property p_out_gated;
		@(posedge ref_clk) disable iff (sys_rst)
		!mclk_on_q |=> !master_clock_out;
	endproperty
	a_out_gated: assert property (p_out_gated) else $error("master clock driven early");
	property p_strap_pin;
		@(posedge ref_clk) disable iff (sys_rst)
		!software_mode |-> !use_crystal || $past(software_mode);
	endproperty
	a_strap_pin: assert property (p_strap_pin) else $error("crystal chosen in strap mode");
	property p_no27_strap;
		@(posedge ref_clk) disable iff (sys_rst)
		!software_mode |-> freq_sel != asac_pkg::FREQ_27M000;
	endproperty
	a_no27_strap: assert property (p_no27_strap) else $error("27 MHz code in strap mode");
	property p_sel_done;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && sel_q == asac_pkg::ASAC_SEL_WAIT && sel_cnt_q >= SRC_SEL_CYCLES |=> sel_q != asac_pkg::ASAC_SEL_WAIT;
	endproperty
	a_sel_done: assert property (p_sel_done) else $error("source not chosen in time");
	property p_frame_len;
		@(posedge ref_clk) disable iff (sys_rst)
		bit_cnt_q <= 6'(asac_pkg::BITS_64 / 2 - 1);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("bit counter out of range");
	property p_lr_on_fall;
		@(posedge ref_clk) disable iff (sys_rst)
		$changed(adc_lr_q) |-> $fell(adc_bc_q);
	endproperty
	a_lr_on_fall: assert property (p_lr_on_fall) else $error("adc frame edge off bit fall");
	property p_pt_full;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && !rate_is_96k && bc_edge |=> pt_bc_q == $past(s2_q[4]);
	endproperty
	a_pt_full: assert property (p_pt_full) else $error("passthrough bit clock lost");
	property p_pt_half;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && rate_is_96k && !bc_rise |=> $stable(pt_bc_q);
	endproperty
	a_pt_half: assert property (p_pt_half) else $error("half rate bit clock moved");
endmodule : asac_top

// File: dv/asac_partner.sv
// far-end model: source of the delay return data
`timescale 1ns/1ps
module asac_partner (
	input wire logic aux_bit_clock,
	output logic delay_return_data_in
);
	// alternating bits, launched on the falling edge so they sit still around the rising edge
	logic bit_q = 1'b0;
	always @(negedge aux_bit_clock) begin
		bit_q <= ~bit_q;
	end
	assign delay_return_data_in = bit_q;
endmodule : asac_partner

// File: dv/asac_top_bench.sv
// self-checking bench for the aux serial audio clocking block
`timescale 1ns/1ps
module asac_top_bench;
	// ============================================================
	// stimulus and observed signals
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic software_mode = 1'b1;
	logic [1:0] master_clock_freq_select = 2'h0;
	logic global_powerdown = 1'b1;
	logic source_is_serial = 1'b0;
	logic rate_is_96k = 1'b0;
	logic ret_ready = 1'b1;
	logic pin_run = 1'b0;
	logic [11:0] pcnt = 12'h000;
	wire logic master_clock_pin, crystal_input, input_frame_clock, input_bit_clock, delay_return_data_in;
	wire logic master_clock_out, master_clock_out_en, use_crystal, aux_frame_clock, aux_bit_clock;
	wire logic ret_valid, ret_data, ret_overflow;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;

	// ============================================================
	// clocks: pin clocks run at a quarter of ref_clk or slower so they can be regenerated
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// one counter makes every slow clock, stepped on the falling edge
	always @(negedge ref_clk) begin
		pcnt <= pcnt + 12'h001;
	end
	// master 4 cycles, bit clock 16, frame 512 (32 bits)
	assign master_clock_pin = pin_run & pcnt[1];
	assign crystal_input = pcnt[1];
	assign input_bit_clock = pcnt[3];
	assign input_frame_clock = pcnt[8];

	// ============================================================
	// design and far-end model
	asac_top #(.SRC_SEL_CYCLES(200)) asac_top_inst (.ref_clk, .sys_rst, .clk_en, .software_mode,
		.master_clock_freq_select, .global_powerdown, .source_is_serial, .rate_is_96k, .master_clock_pin,
		.crystal_input, .input_frame_clock, .input_bit_clock, .delay_return_data_in, .master_clock_out,
		.master_clock_out_en, .use_crystal, .aux_frame_clock, .aux_bit_clock, .ret_valid, .ret_ready,
		.ret_data, .ret_overflow);
	asac_partner asac_partner_inst (.aux_bit_clock, .delay_return_data_in);

	// ============================================================
	// shared helpers
	task automatic chk(input string nm, input int ex, input int got, input int tol);
		n_compared++;
		if (got < ex - tol || got > ex + tol) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got);
		end
	endtask : chk
	task automatic chkb(input string nm, input logic ex, input logic got);
		n_compared++;
		if (got !== ex) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm, ex, got);
		end
	endtask : chkb
	function automatic logic pick(input int w);
		case (w)
			0: return aux_bit_clock;
			1: return aux_frame_clock;
			default: return master_clock_out;
		endcase
	endfunction : pick
	// high and low times in cycles of one full period; no timeout here, a stuck clock waits for the hang guard
	task automatic per(input string nm, input int w, input int half, input int tol);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		while (pick(w) !== 1'b0) @(negedge ref_clk);
		while (pick(w) !== 1'b1) @(negedge ref_clk);
		while (pick(w) === 1'b1) begin
			@(negedge ref_clk);
			hi++;
		end
		while (pick(w) === 1'b0) begin
			@(negedge ref_clk);
			lo++;
		end
		chk({nm, " high"}, half, hi, tol);
		chk({nm, " low"}, half, lo, tol);
	endtask : per
	task automatic do_reset();
		@(negedge ref_clk);
		sys_rst = 1'b1;
		repeat (16) @(negedge ref_clk);
		sys_rst = 1'b0;
	endtask : do_reset

	// ============================================================
	// scenarios
	task automatic t_xtal();
		software_mode = 1'b0;
		do_reset();
		repeat (400) @(negedge ref_clk);
		chkb("strap source", 1'b0, use_crystal);
		software_mode = 1'b1;
		do_reset();
		repeat (260) @(negedge ref_clk);
		chkb("sw source", 1'b1, use_crystal);
		$display("test xtal done");
	endtask : t_xtal
	task automatic t_start();
		int n;
		n = 0;
		pin_run = 1'b1;
		do_reset();
		while (master_clock_out_en !== 1'b1 && n < 6000) begin
			@(negedge ref_clk);
			n++;
		end
		chk("start delay", 4160, n, 4);
		chkb("pin source", 1'b0, use_crystal);
		per("mclk out", 2, 2, 1);
		$display("test start done");
	endtask : t_start
	task automatic t_adc(input logic sw, input logic [1:0] code, input int half);
		global_powerdown = 1'b1;
		software_mode = sw;
		master_clock_freq_select = code;
		repeat (40) @(negedge ref_clk);
		global_powerdown = 1'b0;
		per("adc bit", 0, 16, 1);
		per("adc frame", 1, half, 1);
		$display("test adc done");
	endtask : t_adc
	// jitter of one master period allowed on regenerated edges
	task automatic t_pass(input logic r96, input int m);
		source_is_serial = 1'b1;
		rate_is_96k = r96;
		repeat (1100) @(negedge ref_clk);
		per("pass bit", 0, 8 * m, 4);
		per("pass frame", 1, 256 * m, 4);
		$display("test pass done");
	endtask : t_pass
	// stall the reader until the buffer refuses, then drain it empty
	task automatic t_fifo();
		logic prev;
		int n;
		n = 0;
		ret_ready = 1'b0;
		repeat (640) @(negedge ref_clk);
		chkb("overflow", 1'b1, ret_overflow);
		// release just after a capture so no fresh bit joins the drain
		@(posedge aux_bit_clock);
		@(negedge ref_clk);
		prev = ~ret_data;
		ret_ready = 1'b1;
		while (ret_valid === 1'b1 && n < 40) begin
			chkb("ret bit", ~prev, ret_data);
			prev = ret_data;
			n++;
			@(negedge ref_clk);
		end
		chk("drained", 16, n, 1);
		$display("test fifo done");
	endtask : t_fifo
	// clock enable low must freeze the aux bit clock and the master clock output
	task automatic t_freeze();
		int moves;
		logic bc;
		logic mc;
		moves = 0;
		clk_en = 1'b0;
		bc = aux_bit_clock;
		mc = master_clock_out;
		repeat (100) begin
			@(negedge ref_clk);
			if (aux_bit_clock !== bc || master_clock_out !== mc) moves++;
		end
		chk("frozen moves", 0, moves, 0);
		clk_en = 1'b1;
		$display("test freeze done");
	endtask : t_freeze

	// ============================================================
	// verdict and hang guard
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// ceiling about twice the expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			$display("CHECK FAILED timeout expected end seen hang");
			summarize();
		end
	end
	// main sequence
	initial begin
		t_xtal();
		t_start();
		t_adc(1'b1, 2'h0, 768);
		t_adc(1'b1, 2'h1, 1024);
		t_adc(1'b1, 2'h2, 1024);
		t_adc(1'b0, 2'h2, 1024);
		t_pass(1'b0, 1);
		t_pass(1'b1, 2);
		t_fifo();
		t_freeze();
		summarize();
	end
endmodule : asac_top_bench
